// file: hw/igh_defs.svh
`ifndef IGH_DEFS_SVH
`define IGH_DEFS_SVH

// Number of gated input pins and open-drain capable outputs.
`define IGH_IN_W 8
`define IGH_OUT_W 8
// Reset value of the hold latches and of the participation mask (none take part).
`define IGH_HOLD_RST 8'h00
`define IGH_PART_RST 8'h00
// Reset value of the open-drain selection (all outputs push-pull).
`define IGH_OD_RST 8'h00
// Rail source selection codes.
`define IGH_SRC_PIN 1'h0
`define IGH_SRC_LOGIC 1'h1

`endif

// file: hw/igh_pkg.sv
package igh_pkg;
   // Drive bundle of one output pin group.
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } igh_pin_drv_t;

   // Rail source selection.
   typedef enum logic [0:0] {
      IGH_SRC_PIN_E = 1'b0,
      IGH_SRC_LOGIC_E = 1'b1
   } igh_src_t;
endpackage

// file: hw/igh_od_drv.sv
`timescale 1ns/1ps
`include "igh_defs.svh"

// Per-output driver: push-pull or open-drain, registered.
module igh_od_drv (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Core side.
   input wire logic [`IGH_OUT_W-1:0] data_i,
   input wire logic [`IGH_OUT_W-1:0] od_sel_i,
   // Pin side.
   output igh_pkg::igh_pin_drv_t drv_o
);

   // Open-drain pins only ever drive low; a true value releases the pin.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         drv_o.out <= 8'h00;
         drv_o.oe <= 8'h00;
      end else begin
         drv_o.out <= data_i & ~od_sel_i;
         // Decided bit by bit: a push-pull bit always drives, an open-drain bit only for a false value.
         drv_o.oe <= ~od_sel_i | ~data_i;
      end
   end

   // The drive register lags the selection by one edge, so it is held against the selection it was built from.
   property p_od_low_drive;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (drv_o.oe & $past(od_sel_i) & drv_o.out) == 8'h00;
   endproperty
   a_od_low_drive: assert property (p_od_low_drive) else $error("open-drain output drove high");

endmodule // igh_od_drv

// file: hw/igh_gate.sv
`timescale 1ns/1ps
`include "igh_defs.svh"

module igh_gate (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Configuration.
   input wire logic [`IGH_IN_W-1:0] part_en_i,
   input wire logic rail_src_i,
   input wire logic [`IGH_OUT_W-1:0] od_sel_i,
   // Rail sources.
   input wire logic rail_pin_i,
   input wire logic rail_logic_i,
   // Input pins and core view.
   input wire logic [`IGH_IN_W-1:0] in_pin_i,
   output logic [`IGH_IN_W-1:0] core_data_o,
   // Rail status pin.
   output logic gate_rail_status_pin_o,
   // Output pins.
   input wire logic [`IGH_OUT_W-1:0] core_out_i,
   output igh_pkg::igh_pin_drv_t out_drv_o
);

   logic [`IGH_IN_W-1:0] in_s1;
   logic [`IGH_IN_W-1:0] in_s2;
   logic rail_pin_s1;
   logic rail_pin_s2;
   logic rail;
   logic [`IGH_IN_W-1:0] part;
   logic [`IGH_IN_W-1:0] next_core_data;

   // Pins come from outside the clock domain, so they pass two flops first.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         in_s1 <= `IGH_HOLD_RST;
         in_s2 <= `IGH_HOLD_RST;
         rail_pin_s1 <= 1'h0;
         rail_pin_s2 <= 1'h0;
      end else begin
         in_s1 <= in_pin_i;
         in_s2 <= in_s1;
         rail_pin_s1 <= rail_pin_i;
         rail_pin_s2 <= rail_pin_s1;
      end
   end

   // Participation mask; reset clears it so no pin is gated by default.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         part <= `IGH_PART_RST;
      end else begin
         part <= part_en_i;
      end
   end

   // The dedicated rail cell: one register, fed by a pin or by core logic.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rail <= 1'h0;
      end else if (rail_src_i == `IGH_SRC_LOGIC) begin
         rail <= rail_logic_i;
      end else begin
         rail <= rail_pin_s2;
      end
   end

   // Gated pins keep the core register unchanged, which is the hold latch.
   // Holding at the core register avoids a real latch and its timing hazard.
   always_comb begin
      next_core_data = rail ? ((core_data_o & part) | (in_s2 & ~part)) : in_s2;
   end

   // Core view of the inputs.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         core_data_o <= `IGH_HOLD_RST;
      end else begin
         core_data_o <= next_core_data;
      end
   end

   // Rail level mirrored on its status pin.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         gate_rail_status_pin_o <= 1'h0;
      end else begin
         gate_rail_status_pin_o <= rail;
      end
   end

   // Output drivers with per-pin open-drain choice.
   igh_od_drv u_od (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .data_i(core_out_i),
      .od_sel_i(od_sel_i),
      .drv_o(out_drv_o)
   );

   sequence s_gated_pin0;
      rail && part[0];
   endsequence

   property p_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_gated_pin0 |=> core_data_o[0] == $past(core_data_o[0]);
   endproperty
   a_hold: assert property (p_hold) else $error("gated pin changed");

   property p_pass_low;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !rail |=> core_data_o == $past(in_s2);
   endproperty
   a_pass_low: assert property (p_pass_low) else $error("low rail did not pass");

   property p_pass_nonpart;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (rail && !part[1]) |=> core_data_o[1] == $past(in_s2[1]);
   endproperty
   a_pass_nonpart: assert property (p_pass_nonpart) else $error("free pin blocked");

   property p_status;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> gate_rail_status_pin_o == $past(rail);
   endproperty
   a_status: assert property (p_status) else $error("status pin wrong");

   property p_src;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rail_src_i |=> rail == $past(rail_logic_i);
   endproperty
   a_src: assert property (p_src) else $error("rail source wrong");

   property p_part;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> part == $past(part_en_i);
   endproperty
   a_part: assert property (p_part) else $error("mask not taken");

   property p_resume;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(rail) |=> core_data_o == $past(in_s2);
   endproperty
   a_resume: assert property (p_resume) else $error("no resume");

   property p_od;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      od_sel_i[0] |=> !(out_drv_o.oe[0] && out_drv_o.out[0]);
   endproperty
   a_od: assert property (p_od) else $error("open drain drove high");

   // Every participating pin holds, not only pin 0, for as long as the rail is high.
   // The mask is taken at the same edge as the rail, so a pin that joins mid-hold keeps its value from then.
   property p_hold_all;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rail |=> ((core_data_o ^ $past(core_data_o)) & $past(part)) == 8'h00;
   endproperty
   a_hold_all: assert property (p_hold_all) else $error("a gated pin changed");

   // With the pin as source, the rail copies the second sync stage one edge later.
   // The two stages cost two edges of latency but keep a metastable level away from the hold logic.
   property p_src_pin;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !rail_src_i |=> rail == $past(rail_pin_s2);
   endproperty
   a_src_pin: assert property (p_src_pin) else $error("rail pin source wrong");

   // Reset clears the mask, so a pin only joins the gating once the core asks for it.
   // No disable here: this check is about what happens while reset is held.
   property p_part_rst;
      @(posedge core_clk_i)
      !rst_n_i |=> part == `IGH_PART_RST;
   endproperty
   a_part_rst: assert property (p_part_rst) else $error("mask not cleared by reset");

   // Walk of a rail raised by core logic: source high, rail set, then the status pin.
   sequence s_rail_logic_up;
      rail_src_i && rail_logic_i ##1 rail;
   endsequence

   property p_status_walk;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_rail_logic_up |=> gate_rail_status_pin_o;
   endproperty
   a_status_walk: assert property (p_status_walk) else $error("status pin missed the rail");

   // Walk of a rail drop: rail high, then low; one edge later the core shows the synced pins.
   // A pin that moved during the hold shows up here at once, with no stale value left behind.
   sequence s_rail_drop;
      rail ##1 !rail;
   endsequence

   property p_drop_walk;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_rail_drop |=> core_data_o == $past(in_s2);
   endproperty
   a_drop_walk: assert property (p_drop_walk) else $error("held pins did not resume");

   // Push-pull outputs always drive and carry the core value one edge later.
   property p_push_pull;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !od_sel_i[1] |=> out_drv_o.oe[1] && (out_drv_o.out[1] == $past(core_out_i[1]));
   endproperty
   a_push_pull: assert property (p_push_pull) else $error("push-pull pin not driven");

   // A true value on an open-drain output releases the pin rather than driving it.
   // Whatever pulls the line up on the board then sets its level.
   property p_od_release;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (od_sel_i[0] && core_out_i[0]) |=> !out_drv_o.oe[0];
   endproperty
   a_od_release: assert property (p_od_release) else $error("open-drain pin not released");

endmodule // igh_gate

// file: sim/igh_src_model.sv
`timescale 1ns/1ps

// External drivers of the input pins and of the rail pin.
module igh_src_model (
   // Values the scenario asks for.
   input wire logic [7:0] val_i,
   input wire logic rail_i,
   // Pin levels.
   output logic [7:0] pin_o,
   output logic rail_o
);
   // Pins settle a while after the bench asks, far from any rising edge.
   // One process owns both outputs, so they start low instead of unknown.
   initial begin
      {pin_o, rail_o} = 9'h000;
      forever begin
         @(val_i or rail_i);
         {pin_o, rail_o} <= #20 {val_i, rail_i};
      end
   end
endmodule // igh_src_model

// file: sim/tb.sv
`timescale 1ns/1ps

module tb;
   logic core_clk_i = 0, rst_n_i = 0, rail_src_i = 0, rail_logic_i = 0, src_rail = 0, rail_pin_i;
   logic [7:0] part_en_i = 0, od_sel_i = 0, core_out_i = 0, src_val = 0, in_pin_i, core_data_o;
   logic gate_rail_status_pin_o;
   igh_pkg::igh_pin_drv_t out_drv_o;
   int err_total = 0, compares = 0;
   typedef struct packed {logic [7:0] part; logic src, rail; logic [7:0] a, b, od, dout, held; logic [15:0] drv;} igh_row_t;
   // Mask, rail source, rail level, pins before and during, open-drain select, output data,
   // then the core view expected during the gate and the expected pin drive {out, oe}.
   igh_row_t rows [5] = '{
      '{8'hf0, 1'h0, 1'h1, 8'h5a, 8'ha5, 8'h00, 8'h3c, 8'h55, 16'h3cff},
      '{8'h0f, 1'h1, 1'h1, 8'h5a, 8'ha5, 8'hff, 8'h3c, 8'haa, 16'h00c3},
      '{8'hff, 1'h1, 1'h0, 8'h00, 8'hff, 8'h0f, 8'h96, 8'hff, 16'h90f9},
      '{8'h81, 1'h0, 1'h1, 8'hff, 8'h00, 8'haa, 8'h55, 8'h81, 16'h55ff},
      '{8'h00, 1'h1, 1'h1, 8'h12, 8'hed, 8'h55, 8'hc3, 8'hed, 16'h82be}};

   // Free-running clock.
   initial forever #50 core_clk_i = ~core_clk_i;

   igh_src_model i_src (.val_i(src_val), .rail_i(src_rail), .pin_o(in_pin_i), .rail_o(rail_pin_i));

   igh_gate i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .part_en_i(part_en_i),
      .rail_src_i(rail_src_i), .od_sel_i(od_sel_i), .rail_pin_i(rail_pin_i),
      .rail_logic_i(rail_logic_i), .in_pin_i(in_pin_i), .core_data_o(core_data_o),
      .gate_rail_status_pin_o(gate_rail_status_pin_o), .core_out_i(core_out_i), .out_drv_o(out_drv_o));

   // One compare task per kind of settled result.
   task automatic chk_core(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t core data got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_stat(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t rail status got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_drv(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t pin drive got %h exp %h", $time, got, exp);
      end
   endtask

   // Waits leave room for two sync stages plus the rail register.
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // The unused rail source is held low so only the selected one matters.
   task automatic setr(input logic s, input logic v);
      rail_src_i = s;
      rail_logic_i = s & v;
      src_rail = ~s & v;
   endtask

   task automatic summarize;
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Row loop, then a reset in the middle of a hold.
   initial begin
      wt(20);
      rst_n_i = 1;
      foreach (rows[i]) begin
         part_en_i = rows[i].part;
         od_sel_i = rows[i].od;
         core_out_i = rows[i].dout;
         src_val = rows[i].a;
         setr(rows[i].src, 1'h0);
         wt(6);
         setr(rows[i].src, rows[i].rail);
         wt(6);
         chk_stat(gate_rail_status_pin_o, rows[i].rail);
         src_val = rows[i].b;
         wt(6);
         chk_core(core_data_o, rows[i].held);
         chk_drv(out_drv_o, rows[i].drv);
         setr(rows[i].src, 1'h0);
         wt(6);
         chk_core(core_data_o, rows[i].b);
      end
      // Mask changes under a held rail: a leaving pin follows its pin, a joining pin keeps its value.
      part_en_i = 8'h0f;
      setr(1'h1, 1'h1);
      src_val = 8'h00;
      wt(6);
      chk_core(core_data_o, 8'h0d);
      part_en_i = 8'hf0;
      src_val = 8'hff;
      wt(6);
      chk_core(core_data_o, 8'h0f);
      chk_stat(gate_rail_status_pin_o, 1'h1);
      setr(1'h1, 1'h0);
      wt(6);
      chk_core(core_data_o, 8'hff);
      setr(1'h1, 1'h1);
      wt(6);
      rst_n_i = 0;
      wt(2);
      chk_core(core_data_o, 8'h00);
      chk_stat(gate_rail_status_pin_o, 1'h0);
      setr(1'h1, 1'h0);
      rst_n_i = 1;
      src_val = 8'h3c;
      wt(6);
      chk_core(core_data_o, 8'h3c);
      summarize;
   end

   // The whole run needs 172 cycles, well under the 3000 that this timeout allows.
   initial begin
      #300000;
      err_total++;
      summarize;
   end
endmodule // tb
